// File: iskip_defs.vh
// Purpose: constants for the increment/bit-test skip execution unit
// Assumes: one instruction cycle per clk edge while exec_valid is high
// Notes: opcode selects are plain decoded strobes from the core decoder
// How it works
// - accumulator gets memory plus one, memory unchanged
// - incremented result zero skips next instruction
// - taken skip inserts dummy, three cycles total
// - condition not met, next instruction proceeds normally
// - selected memory bit one skips next instruction
`ifndef ISKIP_DEFS_VH
`define ISKIP_DEFS_VH
`define ISKIP_ACC_RESET 8'h00
`define ISKIP_INC_STEP 8'h01
`define ISKIP_ZERO 8'h00
`define ISKIP_SKIP_CYCLES 2'h3
`define ISKIP_PLAIN_CYCLES 2'h2
`define ISKIP_ST_IDLE 2'h0
`define ISKIP_ST_SECOND 2'h1
`define ISKIP_ST_DUMMY 2'h2
`endif

// File: iskip_unit.v
// Purpose: executes the two conditional-skip instructions of the core
// Assumes: operand byte and bit select are valid with exec_valid
// Notes: a skipping instruction takes three cycles, others two
`timescale 1ns/1ns
`default_nettype none
`include "iskip_defs.vh"
module iskip_unit #(
    parameter DATA_W = 8,
    parameter BIT_W = 3
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // instruction issue
    input wire exec_valid,
    input wire inc_to_acc_skip_zero,
    input wire bit_test_skip_nonzero,
    input wire [DATA_W-1:0] mem_operand,
    input wire [BIT_W-1:0] bit_select,
    // status flags in from the flag register
    input wire [5:0] flags_in,
    // results
    output wire exec_ready,
    output reg [DATA_W-1:0] accumulator_reg,
    output reg acc_write,
    output reg mem_write,
    output reg [5:0] flags_out,
    output reg flags_write,
    output reg skip_next,
    output reg dummy_cycle,
    output reg done
);
    // constants sized to the data path
    localparam [DATA_W-1:0] INC_STEP = `ISKIP_INC_STEP;
    localparam [DATA_W-1:0] ZERO_VAL = `ISKIP_ZERO;
    localparam [DATA_W-1:0] ACC_INIT = `ISKIP_ACC_RESET;

    // sequencer states
    localparam [1:0] ST_IDLE = `ISKIP_ST_IDLE;
    localparam [1:0] ST_SECOND = `ISKIP_ST_SECOND;
    localparam [1:0] ST_DUMMY = `ISKIP_ST_DUMMY;

    // sequencer
    reg [1:0] state;
    reg [1:0] next_state;

    // decode
    reg take_skip;
    wire inc_sel;
    wire bit_sel;
    wire issue;

    // operand paths
    wire [DATA_W-1:0] inc_sum;
    wire inc_zero;
    wire [DATA_W-1:0] bit_hit;
    wire bit_set;

    // sequencer milestones
    wire finish;
    wire leave_busy;
    wire enter_dummy;

    // a new instruction is only taken while idle
    assign exec_ready = (state == ST_IDLE);

    // increment wins when both selects are high
    assign inc_sel = inc_to_acc_skip_zero;
    assign bit_sel = bit_test_skip_nonzero && !inc_to_acc_skip_zero;

    assign issue = exec_valid && exec_ready && (inc_sel || bit_sel);

    // the sum wraps at the data width, so all ones gives zero
    assign inc_sum = mem_operand + INC_STEP;
    assign inc_zero = (inc_sum == ZERO_VAL);

    // one-hot compare per bit position, then or-reduce
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi = gi + 1) begin : bit_pick
            localparam [BIT_W-1:0] IDX = gi;
            assign bit_hit[gi] = (bit_select == IDX) && mem_operand[gi];
        end
    endgenerate

    assign bit_set = |bit_hit;

    always @* begin
        take_skip = 1'b0;
        if (inc_sel) begin
            take_skip = inc_zero;
        end else if (bit_sel) begin
            take_skip = bit_set;
        end
    end

    always @* begin
        case (state)
            ST_IDLE: begin
                if (issue) begin
                    next_state = ST_SECOND;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_SECOND: begin
                // a taken skip spends one more cycle on the dummy
                if (skip_next) begin
                    next_state = ST_DUMMY;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_DUMMY: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // last cycle of the instruction, plain or skipped
    assign finish = (state == ST_SECOND && !skip_next) ||
        (state == ST_DUMMY);
    assign leave_busy = (next_state == ST_IDLE) && (state != ST_IDLE);
    assign enter_dummy = (next_state == ST_DUMMY);

    always @(posedge clk) begin
        if (reset) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // only the increment form writes the accumulator
    always @(posedge clk) begin
        if (reset) begin
            accumulator_reg <= ACC_INIT;
        end else if (issue && inc_sel) begin
            accumulator_reg <= inc_sum;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            acc_write <= 1'b0;
        end else begin
            acc_write <= issue && inc_sel;
        end
    end

    // memory is never written back by either instruction
    always @(posedge clk) begin
        if (reset) begin
            mem_write <= 1'b0;
        end else begin
            mem_write <= 1'b0;
        end
    end

    // flags pass through untouched and are never written
    always @(posedge clk) begin
        if (reset) begin
            flags_out <= 6'h00;
        end else begin
            flags_out <= flags_in;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            flags_write <= 1'b0;
        end else begin
            flags_write <= 1'b0;
        end
    end

    // skip decision held from issue until the instruction ends
    always @(posedge clk) begin
        if (reset) begin
            skip_next <= 1'b0;
        end else if (issue) begin
            skip_next <= take_skip;
        end else if (leave_busy) begin
            skip_next <= 1'b0;
        end
    end

    // marks the inserted dummy instruction cycle
    always @(posedge clk) begin
        if (reset) begin
            dummy_cycle <= 1'b0;
        end else begin
            dummy_cycle <= enter_dummy;
        end
    end

    // one-cycle end pulse, rises together with exec_ready
    always @(posedge clk) begin
        if (reset) begin
            done <= 1'b0;
        end else begin
            done <= finish;
        end
    end

endmodule
`default_nettype wire

// File: iskip_props.sv
// Purpose: port checks; Assumes: one clock; Notes: bound below
`timescale 1ns/1ns
`default_nettype none
module iskip_props (input wire logic clk, reset, exec_valid, exec_ready,
    done, inc_to_acc_skip_zero, bit_test_skip_nonzero, skip_next,
    flags_write, input wire logic [7:0] mem_operand, accumulator_reg,
    input wire logic [2:0] bit_select);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic i = inc_to_acc_skip_zero;
    wire logic g = exec_valid & exec_ready & (i | bit_test_skip_nonzero);
    wire logic t = i ? &mem_operand : mem_operand[bit_select];
    a_acc_inc: assert property (g & i |=>
        accumulator_reg == $past(mem_operand) + 8'h01) else $error("acc");
    a_zero_skip: assert property (g & i & t |=> skip_next)
        else $error("skip");
    a_three_cyc: assert property (g & t |=> !done ##1 !done ##1 done)
        else $error("len");
    a_no_skip: assert property (g & !t |=> !skip_next ##1 done)
        else $error("plain");
    a_bit_skip: assert property (g & !i & t |=> skip_next)
        else $error("bit");
    a_no_flags: assert property (!flags_write) else $error("f");
    c_skip: cover property (g & t);
    c_plain: cover property (g & !t);
    c_bit: cover property (g & !i);
endmodule
bind iskip_unit iskip_props iskip_props_inst (.*);
`default_nettype wire

// File: iskip_unit_tb_top.sv
// Purpose: bench; Assumes: 10 MHz clock; Notes: drives ports directly
`timescale 1ns/1ns
`default_nettype none
module iskip_unit_tb_top;
    reg clk = 0, reset = 1, exec_valid = 0, inc_to_acc_skip_zero = 0;
    reg bit_test_skip_nonzero = 0;
    reg [7:0] mem_operand = 0, e = 0;
    reg [2:0] bit_select = 0;
    reg [5:0] flags_in = 6'h2d;
    wire exec_ready, acc_write, mem_write, flags_write, skip_next, done;
    wire dummy_cycle;
    wire [7:0] accumulator_reg;
    wire [5:0] flags_out;
    integer n_errors = 0, checks = 0, n, k, d;
    always #50 clk = ~clk;
    iskip_unit iskip_unit_inst (.*);
    task chk(input c); begin
        checks++;
        if (!c) begin n_errors++; $display("[FAIL] %0t mismatch", $time); end
    end endtask
    task op(input a, b, input [7:0] v, input [2:0] s, input w); begin
        {exec_valid, inc_to_acc_skip_zero, bit_test_skip_nonzero} = {1'b1, a, b};
        {mem_operand, bit_select, flags_in} = {v, s, ~flags_in};
        if (a) e = v + 8'h01;
        @(posedge clk) #10 exec_valid = 0;
        chk(accumulator_reg === e && acc_write === a && skip_next === w);
        chk(mem_write === 1'b0 && flags_out === flags_in && flags_write === 1'b0);
        chk(exec_ready === 1'b0 && done === 1'b0);
        d = 0;
        for (n = 1; done !== 1'b1 && n < 9; n++) begin
            @(posedge clk) #10;
            if (dummy_cycle === 1'b1) d++;
        end
        chk(n === (w ? 3 : 2) && d === (w ? 1 : 0));
        chk(exec_ready === 1'b1 && skip_next === 1'b0);
        if (n > 8) complete_run;
    end endtask
    task t_inc; begin
        op(1, 0, 8'h41, 0, 0);
        op(1, 0, 8'hff, 0, 1);
    end endtask
    task t_bit; for (k = 0; k < 8; k++) begin
        op(0, 1, 8'h01 << k, k[2:0], 1);
        op(0, 1, ~(8'h01 << k), k[2:0], 0);
    end endtask
    task t_refuse; begin
        {exec_valid, inc_to_acc_skip_zero, bit_test_skip_nonzero} = 3'b100;
        @(posedge clk) #10 exec_valid = 0;
        chk(exec_ready === 1'b1 && acc_write === 1'b0 && skip_next === 1'b0);
        @(posedge clk) #10;
        chk(done === 1'b0 && accumulator_reg === e);
        op(1, 1, 8'h41, 0, 0);
    end endtask
    task t_reset; begin
        {exec_valid, inc_to_acc_skip_zero, mem_operand} = {1'b1, 1'b1, 8'hff};
        bit_test_skip_nonzero = 0;
        @(posedge clk) #10 exec_valid = 0;
        reset = 1;
        @(posedge clk) #10 reset = 0;
        chk(accumulator_reg === 8'h00 && skip_next === 1'b0 && done === 1'b0);
        chk(exec_ready === 1'b1 && dummy_cycle === 1'b0 && acc_write === 1'b0);
        e = 8'h00;
        op(1, 0, 8'h7f, 0, 0);
    end endtask
    task complete_run; begin
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    end endtask
    initial begin
        repeat (5) @(posedge clk);
        #10 reset = 0;
        chk(accumulator_reg === 8'h00 && exec_ready === 1'b1 && done === 1'b0);
        chk(skip_next === 1'b0 && dummy_cycle === 1'b0 && flags_out === 6'h00);
        t_inc;
        t_bit;
        t_refuse;
        t_reset;
        complete_run;
    end
endmodule
`default_nettype wire
